// >>> flash_self_program_pkg.sv
// Overview of operation
// R1 - write and erase only inside the two pages
// R2 - store to trigger address erases its page
// R3 - software erases before writing, once per byte
// R4 - erased page reads as all ones
// R5 - 65h unlocks commands, other values lock
// R6 - keys 4Ah and 4Ch arm byte writes
// R7 - keys BAh and BCh arm page erase
// R8 - store starts only with both keys valid
// R9 - write 20 us, erase 2 ms, processor waits
// R10 - other peripherals keep running during the stall
// R11 - interrupts stay pending, serviced after the write
// R12 - pages readable by code reads
// R13 - unlock register bit 0 shows access enabled
// R14 - key register bit 7 shows enable state
// R15 - time-out flag set by hardware, cleared by zero
// R16 - watchdog select picks time-out, abandons write
// R17 - control bit 3 disables brownout reset
// R18 - software disables brownout reset around writes
// R19 - software clears both keys after each operation
// R20 - software sequence: pointer, unlock, key, store
// R21 - read lock blocks reads of 0000h-01FFh
// R22 - configuration word captured after power-on reset
// R23 - mismatched page or operation changes nothing
// R24 - time-out releases the processor wait
package flash_self_program_pkg;
	// special function register addresses and the configuration word address
	localparam logic [7:0] ADDR_COMMAND_UNLOCK = 8'h97;
	localparam logic [7:0] ADDR_PROGRAM_KEY    = 8'hc9;
	localparam logic [7:0] ADDR_MISC_CONTROL_B = 8'hf7;
	localparam logic [7:0] ADDR_MISC_CONTROL_A = 8'hf8;
	localparam logic [15:0] ADDR_CONFIG_WORD   = 16'h7fff;
	// key codes
	localparam logic [7:0] UNLOCK_CODE  = 8'h65;
	localparam logic [7:0] KEY_WRITE_LO = 8'h4a;
	localparam logic [7:0] KEY_WRITE_HI = 8'h4c;
	localparam logic [7:0] KEY_ERASE_LO = 8'hba;
	localparam logic [7:0] KEY_ERASE_HI = 8'hbc;
	localparam logic [7:0] KEY_CLEAR    = 8'h00;
	// page map
	localparam logic [15:0] PAGE_LO_BASE  = 16'h7a00;
	localparam logic [15:0] PAGE_LO_END   = 16'h7bff;
	localparam logic [15:0] PAGE_HI_BASE  = 16'h7c00;
	localparam logic [15:0] PAGE_HI_END   = 16'h7dff;
	localparam logic [15:0] ERASE_TRIG_LO = 16'h7b2d;
	localparam logic [15:0] ERASE_TRIG_HI = 16'h7d69;
	localparam logic [15:0] LOCK_END      = 16'h01ff;
	localparam int PAGE_BYTES = 512;
	// field positions and reset values
	localparam int ENABLED_BIT      = 0;
	localparam int KEY_ENABLED_BIT  = 7;
	localparam int TIMEOUT_BIT      = 6;
	localparam int WATCHDOG_SEL_LSB = 1;
	localparam int BROWNOUT_BIT     = 3;
	localparam int READ_LOCK_BIT    = 1;
	localparam logic [7:0] MISC_RESET = 8'h00;
	localparam logic [7:0] KEY_RESET  = 8'h00;
	// timing, rounded up to whole cycles
	localparam int CLOCK_PERIOD_NS = 100;
	localparam int WRITE_TIME_NS   = 20000;
	localparam int ERASE_TIME_NS   = 2000000;
	localparam int WD_SHORT_NS     = 800000;
	localparam int WD_MID_NS       = 3200000;
	localparam int WD_LONG_NS      = 6400000;
	localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int WD_SHORT_CYCLES = (WD_SHORT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int WD_MID_CYCLES   = (WD_MID_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int WD_LONG_CYCLES  = (WD_LONG_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	// operation sequencer states
	typedef enum logic [2:0] {
		st_idle  = 3'b001,
		st_write = 3'b010,
		st_erase = 3'b100
	} op_state_type;
endpackage : flash_self_program_pkg

// >>> op_countdown.sv
// cycle countdown; a pulse on done when the loaded count has run out
module op_countdown (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        enable,
	input  wire logic        start,
	input  wire logic        cancel,
	input  wire logic        run,
	input  wire logic [15:0] load_value,
	output logic             done
);
	logic [15:0] count;
	logic        active;
	logic [15:0] next_count;
	logic        next_active;
	logic        next_done;

	// run low pauses the count without losing it
	always_comb begin
		next_count  = count;
		next_active = active;
		next_done   = 1'b0;
		if (start) begin
			next_count  = load_value;
			next_active = 1'b1;
		end else if (cancel) begin
			next_active = 1'b0;
		end else if (active && run) begin
			if (count <= 16'h0001) begin
				next_active = 1'b0;
				next_done   = 1'b1;
			end else begin
				next_count = count - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count  <= 16'h0000;
			active <= 1'b0;
			done   <= 1'b0;
		end else if (enable) begin
			count  <= next_count;
			active <= next_active;
			done   <= next_done;
		end
	end
endmodule : op_countdown

// >>> flash_page_store.sv
// the two self-programmable pages, 1024 bytes
module flash_page_store (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       enable,
	input  wire logic       we,
	input  wire logic       program_only,
	input  wire logic [9:0] waddr,
	input  wire logic [7:0] wdata,
	input  wire logic [9:0] raddr,
	output logic      [7:0] rdata
);
	logic [7:0] mem [0:1023];

	// programming can only clear bits, as real flash cells do
	always_ff @(posedge clk) begin
		if (enable && we) begin
			mem[waddr] <= program_only ? (mem[waddr] & wdata) : wdata;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata <= 8'h00;
		end else if (enable) begin
			rdata <= mem[raddr];
		end
	end
endmodule : flash_page_store

// >>> flash_self_program_ctrl.sv
// self-programming sequencer for the two upper flash pages
module flash_self_program_ctrl #(
	parameter logic [15:0] ERASE_CYCLES    = 16'(flash_self_program_pkg::ERASE_CYCLES),
	parameter logic [15:0] WD_SHORT_CYCLES = 16'(flash_self_program_pkg::WD_SHORT_CYCLES),
	parameter logic [15:0] WD_MID_CYCLES   = 16'(flash_self_program_pkg::WD_MID_CYCLES),
	parameter logic [15:0] WD_LONG_CYCLES  = 16'(flash_self_program_pkg::WD_LONG_CYCLES)
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RESET,
	input  wire logic        CLOCK_ENABLE,
	input  wire logic        SFR_WRITE,
	input  wire logic        SFR_READ,
	input  wire logic [7:0]  SFR_ADDR,
	input  wire logic [7:0]  SFR_WDATA,
	output logic      [7:0]  SFR_RDATA,
	input  wire logic        STORE_REQ,
	input  wire logic [15:0] DATA_POINTER,
	input  wire logic [7:0]  ACCUMULATOR,
	output logic             CPU_WAIT,
	input  wire logic        READ_REQ,
	input  wire logic [15:0] READ_ADDR,
	output logic      [7:0]  READ_RDATA,
	output logic             READ_HIT,
	output logic             READ_BLOCKED,
	input  wire logic [7:0]  CONFIG_WORD_HIGH,
	input  wire logic        PROGRAM_SUPPLY_OK,
	output logic             BROWNOUT_RESET_DISABLE
);
	localparam logic [15:0] WRITE_LOAD = 16'(flash_self_program_pkg::WRITE_CYCLES);

	flash_self_program_pkg::op_state_type state;
	flash_self_program_pkg::op_state_type next_state;
	logic       command_unlock;
	logic [7:0] program_enable_key;
	logic       program_timeout_flag;
	logic [7:0] misc_control_a;
	logic [7:0] misc_control_b;
	logic       low_code_read_lock;
	logic       cfg_loaded;
	logic [7:0] sfr_rdata;
	logic       read_hit;
	logic       read_blocked;
	logic [2:0] supply_sync;
	logic       supply_ok;
	logic [9:0] op_addr;
	logic [7:0] op_data;
	logic [9:0] erase_index;
	logic       next_command_unlock;
	logic [7:0] next_program_enable_key;
	logic       next_program_timeout_flag;
	logic [7:0] next_misc_control_a;
	logic [7:0] next_misc_control_b;
	logic       next_low_code_read_lock;
	logic       next_cfg_loaded;
	logic [7:0] next_sfr_rdata;
	logic       next_read_hit;
	logic       next_read_blocked;
	logic       next_supply_ok;
	logic [9:0] next_op_addr;
	logic [7:0] next_op_data;
	logic [9:0] next_erase_index;
	logic       self_program_enabled;
	logic [1:0] write_watchdog_select;
	logic       in_lo;
	logic       in_hi;
	logic       go_write;
	logic       go_erase;
	logic       op_done;
	logic       wd_done;
	logic       wd_start;
	logic [15:0] wd_load;
	logic       timeout_event;
	logic       arr_we;
	logic       arr_program;
	logic [9:0] arr_waddr;
	logic [7:0] arr_wdata;
	logic [9:0] arr_raddr;

	// both keys must hold a valid code before any store counts
	always_comb begin
		self_program_enabled = command_unlock &&
			(program_enable_key == flash_self_program_pkg::KEY_WRITE_LO ||
			 program_enable_key == flash_self_program_pkg::KEY_WRITE_HI ||
			 program_enable_key == flash_self_program_pkg::KEY_ERASE_LO ||
			 program_enable_key == flash_self_program_pkg::KEY_ERASE_HI); // see R8
		write_watchdog_select = misc_control_b[flash_self_program_pkg::WATCHDOG_SEL_LSB +: 2];
		in_lo = DATA_POINTER >= flash_self_program_pkg::PAGE_LO_BASE &&
			DATA_POINTER <= flash_self_program_pkg::PAGE_LO_END; // see R1
		in_hi = DATA_POINTER >= flash_self_program_pkg::PAGE_HI_BASE &&
			DATA_POINTER <= flash_self_program_pkg::PAGE_HI_END; // see R1
		// operation and page must both match the armed key
		go_write = state == flash_self_program_pkg::st_idle && STORE_REQ && self_program_enabled &&
			((program_enable_key == flash_self_program_pkg::KEY_WRITE_LO && in_lo) ||
			 (program_enable_key == flash_self_program_pkg::KEY_WRITE_HI && in_hi)); // see R6 see R23
		go_erase = state == flash_self_program_pkg::st_idle && STORE_REQ && self_program_enabled &&
			((program_enable_key == flash_self_program_pkg::KEY_ERASE_LO &&
			  DATA_POINTER == flash_self_program_pkg::ERASE_TRIG_LO) ||
			 (program_enable_key == flash_self_program_pkg::KEY_ERASE_HI &&
			  DATA_POINTER == flash_self_program_pkg::ERASE_TRIG_HI)); // see R2 see R7 see R23
		wd_start = go_write && write_watchdog_select != 2'b00; // see R16
		case (write_watchdog_select)
			2'b01:   wd_load = WD_SHORT_CYCLES;
			2'b10:   wd_load = WD_MID_CYCLES;
			default: wd_load = WD_LONG_CYCLES;
		endcase
		timeout_event = state == flash_self_program_pkg::st_write && wd_done; // see R16
	end

	// operation timer pauses while the programming supply is low
	op_countdown op_timer (
		.clk        (CORE_CLK),
		.reset      (RESET),
		.enable     (CLOCK_ENABLE),
		.start      (go_write || go_erase),
		.cancel     (timeout_event),
		.run        (supply_ok),
		.load_value (go_erase ? ERASE_CYCLES : WRITE_LOAD),
		.done       (op_done)
	);

	// write watchdog escapes a byte write that never completes
	op_countdown write_watchdog (
		.clk        (CORE_CLK),
		.reset      (RESET),
		.enable     (CLOCK_ENABLE),
		.start      (wd_start),
		.cancel     (op_done),
		.run        (1'b1),
		.load_value (wd_load),
		.done       (wd_done)
	);

	// register file, read port and configuration capture
	always_comb begin
		next_command_unlock       = command_unlock;
		next_program_enable_key   = program_enable_key;
		next_program_timeout_flag = program_timeout_flag;
		next_misc_control_a       = misc_control_a;
		next_misc_control_b       = misc_control_b;
		next_low_code_read_lock   = low_code_read_lock;
		next_cfg_loaded           = 1'b1;
		next_sfr_rdata            = sfr_rdata;
		next_read_hit             = 1'b0;
		next_read_blocked         = 1'b0;
		next_supply_ok            = supply_ok;
		if (!cfg_loaded) begin
			next_low_code_read_lock = CONFIG_WORD_HIGH[flash_self_program_pkg::READ_LOCK_BIT]; // see R22
		end
		if (supply_sync[2] == supply_sync[1]) begin
			next_supply_ok = supply_sync[2];
		end
		if (SFR_WRITE) begin
			case (SFR_ADDR)
				flash_self_program_pkg::ADDR_COMMAND_UNLOCK:
					next_command_unlock = SFR_WDATA == flash_self_program_pkg::UNLOCK_CODE; // see R5
				flash_self_program_pkg::ADDR_PROGRAM_KEY: begin
					next_program_enable_key = SFR_WDATA; // see R6 see R7
					if (SFR_WDATA == flash_self_program_pkg::KEY_CLEAR) begin
						next_program_timeout_flag = 1'b0; // see R15
					end
				end
				flash_self_program_pkg::ADDR_MISC_CONTROL_B: next_misc_control_b = SFR_WDATA;
				flash_self_program_pkg::ADDR_MISC_CONTROL_A: next_misc_control_a = SFR_WDATA;
				default: next_sfr_rdata = sfr_rdata;
			endcase
		end
		// a time-out in the same cycle as the clear wins
		if (timeout_event) begin
			next_program_timeout_flag = 1'b1; // see R15
		end
		if (SFR_READ) begin
			case (SFR_ADDR)
				flash_self_program_pkg::ADDR_COMMAND_UNLOCK:
					next_sfr_rdata = {7'h00, self_program_enabled}; // see R13
				flash_self_program_pkg::ADDR_PROGRAM_KEY:
					next_sfr_rdata = {self_program_enabled, program_timeout_flag, 6'h00}; // see R14
				flash_self_program_pkg::ADDR_MISC_CONTROL_B: next_sfr_rdata = misc_control_b;
				flash_self_program_pkg::ADDR_MISC_CONTROL_A: next_sfr_rdata = misc_control_a;
				default: next_sfr_rdata = 8'h00;
			endcase
		end
		if (READ_REQ) begin
			next_read_blocked = !low_code_read_lock &&
				READ_ADDR <= flash_self_program_pkg::LOCK_END; // see R21
			next_read_hit = READ_ADDR >= flash_self_program_pkg::PAGE_LO_BASE &&
				READ_ADDR <= flash_self_program_pkg::PAGE_HI_END; // see R12
		end
	end

	// the lock defaults to closed until the word is captured
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			command_unlock         <= 1'b0;
			program_enable_key     <= flash_self_program_pkg::KEY_RESET;
			program_timeout_flag   <= 1'b0;
			misc_control_a         <= flash_self_program_pkg::MISC_RESET;
			misc_control_b         <= flash_self_program_pkg::MISC_RESET;
			low_code_read_lock     <= 1'b0;
			cfg_loaded             <= 1'b0;
			sfr_rdata              <= 8'h00;
			READ_HIT               <= 1'b0;
			READ_BLOCKED           <= 1'b0;
			supply_sync            <= 3'b000;
			supply_ok              <= 1'b0;
			BROWNOUT_RESET_DISABLE <= 1'b0;
		end else if (CLOCK_ENABLE) begin
			command_unlock         <= next_command_unlock;
			program_enable_key     <= next_program_enable_key;
			program_timeout_flag   <= next_program_timeout_flag;
			misc_control_a         <= next_misc_control_a;
			misc_control_b         <= next_misc_control_b;
			low_code_read_lock     <= next_low_code_read_lock;
			cfg_loaded             <= next_cfg_loaded;
			sfr_rdata              <= next_sfr_rdata;
			READ_HIT               <= next_read_hit;
			READ_BLOCKED           <= next_read_blocked;
			supply_sync            <= {supply_sync[1:0], PROGRAM_SUPPLY_OK};
			supply_ok              <= next_supply_ok;
			BROWNOUT_RESET_DISABLE <= next_misc_control_a[flash_self_program_pkg::BROWNOUT_BIT]; // see R17
		end
	end
	assign SFR_RDATA = sfr_rdata;

	// operation sequencer; only the processor stalls, interrupts stay pending outside
	always_comb begin
		next_state       = state;
		next_op_addr     = op_addr;
		next_op_data     = op_data;
		next_erase_index = erase_index;
		arr_we           = 1'b0;
		arr_program      = 1'b1;
		arr_waddr        = op_addr;
		arr_wdata        = op_data;
		case (state)
			flash_self_program_pkg::st_idle: begin
				next_op_addr     = {in_hi, DATA_POINTER[8:0]}; // see R8
				next_op_data     = ACCUMULATOR; // see R8
				next_erase_index = 10'h000;
				if (go_erase) begin
					next_state = flash_self_program_pkg::st_erase; // see R2
				end else if (go_write) begin
					next_state = flash_self_program_pkg::st_write; // see R6
				end
			end
			flash_self_program_pkg::st_write: begin
				// data lands only at the end, so a time-out leaves the byte untouched
				if (timeout_event) begin
					next_state = flash_self_program_pkg::st_idle; // see R24
				end else if (op_done) begin
					arr_we     = 1'b1;
					next_state = flash_self_program_pkg::st_idle; // see R9
				end
			end
			flash_self_program_pkg::st_erase: begin
				// one byte per cycle, well inside the erase time
				if (!erase_index[9]) begin
					arr_we           = 1'b1;
					arr_program      = 1'b0;
					arr_waddr        = {op_addr[9], erase_index[8:0]};
					arr_wdata        = 8'hff; // see R4
					next_erase_index = erase_index + 10'h001;
				end
				if (op_done) begin
					next_state = flash_self_program_pkg::st_idle; // see R9
				end
			end
			default: next_state = flash_self_program_pkg::st_idle;
		endcase
		arr_raddr = {READ_ADDR >= flash_self_program_pkg::PAGE_HI_BASE, READ_ADDR[8:0]};
	end

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			state       <= flash_self_program_pkg::st_idle;
			op_addr     <= 10'h000;
			op_data     <= 8'h00;
			erase_index <= 10'h000;
			CPU_WAIT    <= 1'b0;
		end else if (CLOCK_ENABLE) begin
			state       <= next_state;
			op_addr     <= next_op_addr;
			op_data     <= next_op_data;
			erase_index <= next_erase_index;
			CPU_WAIT    <= next_state != flash_self_program_pkg::st_idle; // see R9 see R10 see R11
		end
	end

	flash_page_store pages (
		.clk          (CORE_CLK),
		.reset        (RESET),
		.enable       (CLOCK_ENABLE),
		.we           (arr_we),
		.program_only (arr_program),
		.waddr        (arr_waddr),
		.wdata        (arr_wdata),
		.raddr        (arr_raddr),
		.rdata        (READ_RDATA)
	);

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RESET || !CLOCK_ENABLE);

	a_outside_no_op: assert property (STORE_REQ && state == flash_self_program_pkg::st_idle && !in_lo && !in_hi |=> !CPU_WAIT) else $error("store outside pages started an operation"); // see R1
	a_erase_trigger_go: assert property (go_erase |=> state == flash_self_program_pkg::st_erase && CPU_WAIT) else $error("erase trigger did not start erase"); // see R2
	a_erase_ones: assert property (state == flash_self_program_pkg::st_erase && !erase_index[9] |-> arr_we && arr_wdata == 8'hff && !arr_program) else $error("erase sweep skipped a byte"); // see R4
	a_unlock_write: assert property (SFR_WRITE && SFR_ADDR == flash_self_program_pkg::ADDR_COMMAND_UNLOCK && SFR_WDATA != flash_self_program_pkg::UNLOCK_CODE |=> !self_program_enabled) else $error("unlock not cleared"); // see R5
	a_mismatch_ignored: assert property (STORE_REQ && state == flash_self_program_pkg::st_idle && program_enable_key == flash_self_program_pkg::KEY_WRITE_LO && in_hi |=> state == flash_self_program_pkg::st_idle) else $error("wrong page was written"); // see R23
	a_wait_tracks_op: assert property ($rose(CPU_WAIT) |-> $past(go_write || go_erase)) else $error("wait rose without an accepted store"); // see R9
	a_status_read: assert property (SFR_READ && SFR_ADDR == flash_self_program_pkg::ADDR_PROGRAM_KEY |=> SFR_RDATA == {$past(self_program_enabled), $past(program_timeout_flag), 6'h00}) else $error("key status read wrong"); // see R14
	a_unlock_read: assert property (SFR_READ && SFR_ADDR == flash_self_program_pkg::ADDR_COMMAND_UNLOCK |=> SFR_RDATA == {7'h00, $past(self_program_enabled)}) else $error("enable flag read wrong"); // see R13
	a_timeout_release: assert property (timeout_event |=> program_timeout_flag && !CPU_WAIT ##1 !arr_we) else $error("time-out did not release"); // see R16 see R24
	a_flag_clear: assert property (SFR_WRITE && SFR_ADDR == flash_self_program_pkg::ADDR_PROGRAM_KEY && SFR_WDATA == 8'h00 && !timeout_event |=> !program_timeout_flag) else $error("time-out flag not cleared"); // see R15
	a_read_lock: assert property (READ_REQ && !low_code_read_lock && READ_ADDR <= 16'h01ff |=> READ_BLOCKED) else $error("locked read not blocked"); // see R21
	a_brownout_bit: assert property (SFR_WRITE && SFR_ADDR == flash_self_program_pkg::ADDR_MISC_CONTROL_A |=> BROWNOUT_RESET_DISABLE == $past(SFR_WDATA[3])) else $error("brownout disable not following"); // see R17
endmodule : flash_self_program_ctrl

// >>> cpu_model.sv
// processor core side: register writes, reads, stores and code reads
module cpu_model (
	input  wire logic        clk,
	output logic             sfr_write,
	output logic             sfr_read,
	output logic      [7:0]  sfr_addr,
	output logic      [7:0]  sfr_wdata,
	output logic             store_req,
	output logic      [15:0] data_pointer,
	output logic      [7:0]  accumulator,
	output logic             read_req,
	output logic      [15:0] read_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus at time zero
	initial begin
		{sfr_write, sfr_read, store_req, read_req} = 4'h0;
		{sfr_addr, sfr_wdata, accumulator} = 24'h000000;
		{data_pointer, read_addr} = 32'h00000000;
	end
	// released data flips so a stale value never looks valid
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_write <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge clk);
		sfr_write <= 1'b0;
		sfr_wdata <= ~d;
	endtask : sfr_wr
	// returns just after the taking edge, read data settled
	task automatic sfr_rd(input logic [7:0] a);
		@(posedge clk);
		sfr_read <= 1'b1;
		sfr_addr <= a;
		@(posedge clk);
		sfr_read <= 1'b0;
		#1;
	endtask : sfr_rd
	task automatic code_rd(input logic [15:0] p);
		@(posedge clk);
		read_req <= 1'b1;
		read_addr <= p;
		@(posedge clk);
		read_req <= 1'b0;
		read_addr <= ~p;
		#1;
	endtask : code_rd
	// pointer, unlock, key, then store
	task automatic op(input logic [7:0] u, input logic [7:0] k, input logic [15:0] p,
			input logic [7:0] d);
		@(posedge clk);
		data_pointer <= p;
		sfr_wr(8'h97, u);
		sfr_wr(8'hc9, k);
		@(posedge clk);
		store_req <= 1'b1;
		accumulator <= d;
		@(posedge clk);
		store_req <= 1'b0;
		accumulator <= ~d;
	endtask : op
endmodule : cpu_model

// >>> tb_flash_self_program_ctrl.sv
module tb_flash_self_program_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int ERASE_N = 600;
	localparam int WD_N [3] = '{300, 400, 500};
	logic        CORE_CLK = 1'b0;
	logic        RESET = 1'b1;
	logic        SFR_WRITE, SFR_READ, STORE_REQ, READ_REQ, CPU_WAIT;
	logic [7:0]  SFR_ADDR, SFR_WDATA, SFR_RDATA, ACCUMULATOR, READ_RDATA;
	logic [15:0] DATA_POINTER, READ_ADDR;
	logic        READ_HIT, READ_BLOCKED, BROWNOUT_RESET_DISABLE;
	logic        PROGRAM_SUPPLY_OK = 1'b1;
	logic        CLOCK_ENABLE = 1'b1;
	logic [7:0]  CONFIG_WORD_HIGH = 8'h00;
	int          miscompares = 0;
	int          checked = 0;
	int          n;
	// shortened erase and watchdog counts keep the run brief
	flash_self_program_ctrl #(.ERASE_CYCLES(16'(ERASE_N)), .WD_SHORT_CYCLES(16'(WD_N[0])),
		.WD_MID_CYCLES(16'(WD_N[1])), .WD_LONG_CYCLES(16'(WD_N[2]))) i_dut (
		.CORE_CLK(CORE_CLK), .RESET(RESET), .CLOCK_ENABLE(CLOCK_ENABLE),
		.SFR_WRITE(SFR_WRITE), .SFR_READ(SFR_READ), .SFR_ADDR(SFR_ADDR),
		.SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .STORE_REQ(STORE_REQ),
		.DATA_POINTER(DATA_POINTER), .ACCUMULATOR(ACCUMULATOR), .CPU_WAIT(CPU_WAIT),
		.READ_REQ(READ_REQ), .READ_ADDR(READ_ADDR), .READ_RDATA(READ_RDATA),
		.READ_HIT(READ_HIT), .READ_BLOCKED(READ_BLOCKED),
		.CONFIG_WORD_HIGH(CONFIG_WORD_HIGH), .PROGRAM_SUPPLY_OK(PROGRAM_SUPPLY_OK),
		.BROWNOUT_RESET_DISABLE(BROWNOUT_RESET_DISABLE));
	cpu_model i_cpu (
		.clk(CORE_CLK), .sfr_write(SFR_WRITE), .sfr_read(SFR_READ), .sfr_addr(SFR_ADDR),
		.sfr_wdata(SFR_WDATA), .store_req(STORE_REQ), .data_pointer(DATA_POINTER),
		.accumulator(ACCUMULATOR), .read_req(READ_REQ), .read_addr(READ_ADDR));
	// 10 MHz core clock
	always #50 CORE_CLK = ~CORE_CLK;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// stall counts may slip a cycle or two through registering
	task automatic near(input int c, input int e);
		chk(16'((c >= e - 2 && c <= e + 2) ? e : c), 16'(e));
	endtask : near
	task automatic sfr(input logic [7:0] a, input logic [7:0] e);
		i_cpu.sfr_rd(a);
		chk(16'(SFR_RDATA), 16'(e));
	endtask : sfr
	// result packed as {blocked, hit, data}; data only counts on a hit
	task automatic code(input logic [15:0] p, input logic [15:0] e);
		i_cpu.code_rd(p);
		chk({6'h00, READ_BLOCKED, READ_HIT, (READ_HIT === 1'b1) ? READ_RDATA : 8'h00}, e);
	endtask : code
	// counts stall cycles; gives up early when the store was refused
	task automatic run_op(input logic [7:0] u, input logic [7:0] k, input logic [15:0] p,
			input logic [7:0] d);
		i_cpu.op(u, k, p, d);
		n = 0;
		for (int i = 0; i < 2000; i++) begin
			@(posedge CORE_CLK);
			#1;
			if (CPU_WAIT === 1'b1) n++;
			else if (n > 0 || i > 3) break;
		end
	endtask : run_op
	task automatic lock;
		i_cpu.sfr_wr(8'h97, 8'h00);
		i_cpu.sfr_wr(8'hc9, 8'h00);
	endtask : lock
	task automatic t_regs;
		sfr(8'hf7, 8'h00);
		sfr(8'hc9, 8'h00);
		sfr(8'h97, 8'h00);
		sfr(8'h80, 8'h00);
		i_cpu.sfr_wr(8'hf8, 8'h08);
		@(posedge CORE_CLK);
		#1;
		chk(16'(BROWNOUT_RESET_DISABLE), 16'h0001);
		sfr(8'hf8, 8'h08);
	endtask : t_regs
	task automatic t_keys;
		logic [7:0] keys [4] = '{8'h4a, 8'h4c, 8'hba, 8'hbc};
		i_cpu.sfr_wr(8'h97, 8'h65);
		foreach (keys[i]) begin
			i_cpu.sfr_wr(8'hc9, keys[i]);
			sfr(8'hc9, 8'h80);
			sfr(8'h97, 8'h01);
		end
		i_cpu.sfr_wr(8'hc9, 8'h11);
		sfr(8'hc9, 8'h00);
		i_cpu.sfr_wr(8'hc9, 8'h4a);
		i_cpu.sfr_wr(8'h97, 8'h64);
		sfr(8'h97, 8'h00);
		lock();
	endtask : t_keys
	// erase both pages first, so later writes land on blank bytes
	task automatic t_erase;
		for (int i = 0; i < 2; i++) begin
			run_op(8'h65, i ? 8'hbc : 8'hba, i ? 16'h7d69 : 16'h7b2d, 8'h00);
			near(n, ERASE_N);
			code(i ? 16'h7c00 : 16'h7a00, 16'h01ff);
			code(i ? 16'h7dff : 16'h7bff, 16'h01ff);
			lock();
		end
	endtask : t_erase
	task automatic t_write;
		logic [7:0]  us [5] = '{8'h65, 8'h65, 8'h65, 8'h65, 8'h64};
		logic [7:0]  ks [5] = '{8'h4a, 8'h4c, 8'h4a, 8'hba, 8'h4a};
		logic [15:0] ps [5] = '{16'h7c10, 16'h7a10, 16'h7e00, 16'h7a20, 16'h7a30};
		run_op(8'h65, 8'h4a, 16'h7a00, 8'h5a);
		near(n, 200);
		code(16'h7a00, 16'h015a);
		run_op(8'h65, 8'h4c, 16'h7dff, 8'ha5);
		near(n, 200);
		code(16'h7dff, 16'h01a5);
		foreach (ps[i]) begin
			run_op(us[i], ks[i], ps[i], 8'h00);
			chk(16'(n), 16'h0000);
			code(ps[i], (ps[i] <= 16'h7dff) ? 16'h01ff : 16'h0000);
		end
		lock();
	endtask : t_write
	// a weak supply stalls the write until the watchdog gives up
	task automatic t_timeout;
		PROGRAM_SUPPLY_OK <= 1'b0;
		repeat (5) @(posedge CORE_CLK);
		for (int w = 1; w < 4; w++) begin
			i_cpu.sfr_wr(8'hf7, 8'(w << 1));
			sfr(8'hf7, 8'(w << 1));
			run_op(8'h65, 8'h4a, 16'h7a40, 8'h00);
			near(n, WD_N[w - 1]);
			sfr(8'hc9, 8'hc0);
			i_cpu.sfr_wr(8'hc9, 8'h00);
			sfr(8'hc9, 8'h00);
			code(16'h7a40, 16'h01ff);
		end
		lock();
		PROGRAM_SUPPLY_OK <= 1'b1;
		i_cpu.sfr_wr(8'hf7, 8'h00);
	endtask : t_timeout
	task automatic t_lock;
		code(16'h0000, 16'h0200);
		code(16'h01ff, 16'h0200);
		code(16'h0200, 16'h0000);
	endtask : t_lock
	// a frozen clock enable must swallow a register write
	task automatic t_freeze;
		@(posedge CORE_CLK);
		CLOCK_ENABLE <= 1'b0;
		i_cpu.sfr_wr(8'hf7, 8'h06);
		CLOCK_ENABLE <= 1'b1;
		sfr(8'hf7, 8'h00);
	endtask : t_freeze
	// second reset in mid-run, now with the read lock open
	task automatic t_reset;
		@(posedge CORE_CLK);
		CONFIG_WORD_HIGH <= 8'h02;
		RESET <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		RESET <= 1'b0;
		code(16'h0000, 16'h0000);
		chk(16'(BROWNOUT_RESET_DISABLE), 16'h0000);
		sfr(8'hc9, 8'h00);
	endtask : t_reset
	task automatic final_report;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	// main sequence after a 16-cycle reset
	initial begin
		repeat (16) @(posedge CORE_CLK);
		RESET <= 1'b0;
		t_regs();
		t_freeze();
		t_keys();
		t_erase();
		t_write();
		t_timeout();
		t_lock();
		t_reset();
		final_report();
	end
	// whole run needs about 3100 cycles
	initial begin
		#3000000;
		miscompares++;
		final_report();
	end
endmodule : tb_flash_self_program_ctrl
